/* File: port5_gpio.sv */
// Eight-pin port: data latch, direction, pull-up and function registers.
// Assumes a byte register port with one-cycle strobes and synchronous pins.
// Behaviour
// - Output-direction pins read back the data latch value.
// - Input-direction pins read back the sampled pin level.
// - Direction bit one drives pin from latch, zero makes it input.
// - Direction and latch drive pins only in general I/O use.
// - Direction register is write-only and reads as all ones.
// - Input pin pull-up follows its pull-up enable bit.
// - Pull-up off for output pins and after reset.
// - Mode bit zero gives general I/O, one gives wake-up input.
// - Upper pins become segment outputs when field top bit set.
// - Lower pins become segment outputs on field pattern 1**1.
// - Reset clears data, direction, pull-up and mode registers.
// - In standby pins float except pulled-up pins show high.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module port5_gpio #(
  parameter int WIDTH = port5_pkg::PORT_WIDTH
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [15:0]          addr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [7:0]           rdata,
  input  wire logic [3:0]           segment_select_field,
  input  wire logic [WIDTH-1:0]     lcd_segment_output,
  input  wire logic [2:0]           op_mode,
  input  wire logic [WIDTH-1:0]     pin_in,
  output logic      [WIDTH-1:0]     pin_out,
  output logic      [WIDTH-1:0]     pin_oe,
  output logic      [WIDTH-1:0]     pullup_on,
  output logic      [WIDTH-1:0]     wakeup_in,
  output logic      [WIDTH-1:0]     seg_active
);
  logic [WIDTH-1:0] port_data_latch;
  logic [WIDTH-1:0] port_direction;
  logic [WIDTH-1:0] port_pullup_enable;
  logic [WIDTH-1:0] port_function_select;

  wire logic [WIDTH-1:0] cell_oe;
  wire logic [WIDTH-1:0] cell_out;
  wire logic [WIDTH-1:0] cell_pu;
  wire logic [WIDTH-1:0] cell_wake;
  wire logic [WIDTH-1:0] cell_seg;

  // Address decode
  wire logic sel_func = (addr == port5_pkg::ADDR_FUNC_SEL);
  wire logic sel_data = (addr == port5_pkg::ADDR_DATA_LATCH);
  wire logic sel_pull = (addr == port5_pkg::ADDR_PULLUP_EN);
  wire logic sel_dir  = (addr == port5_pkg::ADDR_DIRECTION);

  // Mode decode; hold covers sleep, subsleep and watch
  wire logic mode_standby = (op_mode == 3'(port5_pkg::MODE_STANDBY));
  wire logic mode_hold    = (op_mode == 3'(port5_pkg::MODE_SLEEP))
                          | (op_mode == 3'(port5_pkg::MODE_SUBSLEEP))
                          | (op_mode == 3'(port5_pkg::MODE_WATCH));

  wire logic [WIDTH-1:0] data_view =
    (port_direction & port_data_latch) | (~port_direction & pin_in);

  // Read mux; unmapped addresses answer zero
  wire logic [7:0] next_rdata =
    sel_data ? 8'(data_view) :
    sel_dir  ? port5_pkg::DIR_READ_VALUE :
    sel_pull ? 8'(port_pullup_enable) :
    sel_func ? 8'(port_function_select) :
    port5_pkg::UNMAPPED_VALUE;

  // Per-pin function cells
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_pin
      port5_pin_cell #(
        .UPPER_HALF (g >= 4)
      ) u_cell (
        .direction            (port_direction[g]),
        .latch                (port_data_latch[g]),
        .wakeup_select_bit    (port_function_select[g]),
        .pullup_en            (port_pullup_enable[g]),
        .seg_level            (lcd_segment_output[g]),
        .segment_select_field (segment_select_field),
        .seg_use              (cell_seg[g]),
        .drive_oe             (cell_oe[g]),
        .drive_out            (cell_out[g]),
        .pullup_on            (cell_pu[g]),
        .wake_use             (cell_wake[g])
      );
    end
  endgenerate

  wire logic [WIDTH-1:0] next_oe  = mode_standby ? '0 :
                                    mode_hold ? pin_oe : cell_oe;
  wire logic [WIDTH-1:0] next_out = mode_standby ? '0 :
                                    mode_hold ? pin_out : cell_out;
  wire logic [WIDTH-1:0] next_pu  = mode_hold ? pullup_on : cell_pu;

  // Register writes
  // clear on reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      port_data_latch      <= WIDTH'(port5_pkg::RESET_VALUE);
      port_direction       <= WIDTH'(port5_pkg::RESET_VALUE);
      port_pullup_enable   <= WIDTH'(port5_pkg::RESET_VALUE);
      port_function_select <= WIDTH'(port5_pkg::RESET_VALUE);
    end
    else if (wr)
    begin
      if (sel_data) port_data_latch      <= WIDTH'(wdata);
      if (sel_dir)  port_direction       <= WIDTH'(wdata);
      if (sel_pull) port_pullup_enable   <= WIDTH'(wdata);
      if (sel_func) port_function_select <= WIDTH'(wdata);
    end
  end

  // Read data valid the cycle after the strobe only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= 8'h00;
    else
      rdata <= rd ? next_rdata : 8'h00;
  end

  // Pin outputs registered; pins float during reset
  // float in reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_oe     <= '0;
      pin_out    <= '0;
      pullup_on  <= '0;
      wakeup_in  <= '0;
      seg_active <= '0;
    end
    else
    begin
      pin_oe     <= next_oe;
      pin_out    <= next_out;
      pullup_on  <= next_pu;
      wakeup_in  <= cell_wake & pin_in;
      seg_active <= cell_seg;
    end
  end

  // Reset release sees all four registers, pin_oe and pullup_on cleared
  sequence s_reset_release;
    $rose(nrst);
  endsequence
  property p_reset_clear;
    @(posedge clk) disable iff (!nrst)
    s_reset_release
      |-> (port_data_latch | port_direction | port_pullup_enable
           | port_function_select | pin_oe | pullup_on) == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("Registers not cleared by reset");

  // Read-back checks work per bit, so mixed directions are covered
  property p_data_read;
    @(posedge clk) disable iff (!nrst)
    (rd && sel_data)
      |=> ((rdata ^ 8'($past(port_data_latch)))
           & 8'($past(port_direction))) == 8'h00;
  endproperty
  a_data_read: assert property (p_data_read)
    else $error("Output pin read not latch value");

  property p_input_pin_read;
    @(posedge clk) disable iff (!nrst)
    (rd && sel_data)
      |=> ((rdata ^ 8'($past(pin_in)))
           & ~8'($past(port_direction))) == 8'h00;
  endproperty
  a_input_pin_read: assert property (p_input_pin_read)
    else $error("Input pin read not pin level");

  property p_dir_reads_ones;
    @(posedge clk) disable iff (!nrst)
    (rd && sel_dir) |=> rdata == port5_pkg::DIR_READ_VALUE;
  endproperty
  a_dir_reads_ones: assert property (p_dir_reads_ones)
    else $error("Direction read not all ones");

  property p_pullup_off_out;
    @(posedge clk) disable iff (!nrst)
    (!mode_hold && port_direction != '0)
      |=> (pullup_on & $past(port_direction)) == '0;
  endproperty
  a_pullup_off_out: assert property (p_pullup_off_out)
    else $error("Pull-up on for output pin");

  sequence s_standby;
    mode_standby;
  endsequence
  property p_standby_float;
    @(posedge clk) disable iff (!nrst)
    s_standby |=> pin_oe == '0;
  endproperty
  a_standby_float: assert property (p_standby_float)
    else $error("Pin driven in standby");

  property p_hold;
    @(posedge clk) disable iff (!nrst)
    mode_hold |=> pin_oe == $past(pin_oe) && pin_out == $past(pin_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Pins changed in sleep");

  property p_upper_seg;
    @(posedge clk) disable iff (!nrst)
    (segment_select_field[3] && !mode_hold && !mode_standby)
      |=> seg_active[7:4] == 4'hF && pin_oe[7:4] == 4'hF;
  endproperty
  a_upper_seg: assert property (p_upper_seg)
    else $error("Upper pins not segment");

  property p_lower_seg;
    @(posedge clk) disable iff (!nrst)
    (segment_select_field[3] && !segment_select_field[0])
      |=> seg_active[3:0] == 4'h0;
  endproperty
  a_lower_seg: assert property (p_lower_seg)
    else $error("Lower pins wrongly segment");

  property p_wake_no_drive;
    @(posedge clk) disable iff (!nrst)
    (!mode_hold && !mode_standby && segment_select_field[3] == 1'b0)
      |=> (pin_oe & $past(port_function_select)) == '0;
  endproperty
  a_wake_no_drive: assert property (p_wake_no_drive)
    else $error("Wake-up pin driven");

  property p_drive_output;
    @(posedge clk) disable iff (!nrst)
    (!mode_hold && !mode_standby && segment_select_field == 4'h0
      && port_function_select == '0)
      |=> pin_oe == $past(port_direction)
          && (pin_out & pin_oe) == ($past(port_data_latch) & pin_oe);
  endproperty
  a_drive_output: assert property (p_drive_output)
    else $error("Output drive mismatch");

  // Segment pins carry the controller levels, not the latch
  property p_seg_level;
    @(posedge clk) disable iff (!nrst)
    (!mode_hold && !mode_standby)
      |=> ((pin_out ^ $past(lcd_segment_output)) & seg_active) == '0;
  endproperty
  a_seg_level: assert property (p_seg_level)
    else $error("Segment pin not driven from controller");

  property p_lower_seg_on;
    @(posedge clk) disable iff (!nrst)
    (segment_select_field[3] && segment_select_field[0]
      && !mode_hold && !mode_standby)
      |=> seg_active[3:0] == 4'hF && pin_oe[3:0] == 4'hF;
  endproperty
  a_lower_seg_on: assert property (p_lower_seg_on)
    else $error("Lower pins not segment");

  property p_no_seg;
    @(posedge clk) disable iff (!nrst)
    !segment_select_field[3] |=> seg_active == '0;
  endproperty
  a_no_seg: assert property (p_no_seg)
    else $error("Segment use with field top bit clear");

  // Direction drives only pins left in general I/O use
  property p_gpio_gate;
    @(posedge clk) disable iff (!nrst)
    (!mode_hold && !mode_standby)
      |=> ((pin_oe ^ $past(port_direction)) & ~seg_active
           & ~$past(port_function_select)) == '0;
  endproperty
  a_gpio_gate: assert property (p_gpio_gate)
    else $error("General I/O pin drive not from direction");

  // Wake-up outputs pass the pin level only on wake-up pins
  property p_wake_level;
    @(posedge clk) disable iff (!nrst)
    1'b1 |=> wakeup_in == ($past(pin_in)
                           & $past(port_function_select) & ~seg_active);
  endproperty
  a_wake_level: assert property (p_wake_level)
    else $error("Wake-up level mismatch");

  // Input pins outside segment use follow the pull-up enable
  property p_pullup_follow;
    @(posedge clk) disable iff (!nrst)
    (!mode_hold && port_direction == '0 && !segment_select_field[3])
      |=> pullup_on == $past(port_pullup_enable);
  endproperty
  a_pullup_follow: assert property (p_pullup_follow)
    else $error("Input pin pull-up not following enable");

  property p_hold_pullup;
    @(posedge clk) disable iff (!nrst)
    mode_hold |=> pullup_on == $past(pullup_on);
  endproperty
  a_hold_pullup: assert property (p_hold_pullup)
    else $error("Pull-ups changed in sleep");

  // Released pins rest low so no stale level returns on wake
  property p_standby_low;
    @(posedge clk) disable iff (!nrst)
    s_standby |=> pin_out == '0;
  endproperty
  a_standby_low: assert property (p_standby_low)
    else $error("Pin output not cleared in standby");

  // Each register takes the written byte on the next edge
  property p_latch_write;
    @(posedge clk) disable iff (!nrst)
    (wr && sel_data) |=> 8'(port_data_latch) == $past(wdata);
  endproperty
  a_latch_write: assert property (p_latch_write)
    else $error("Data latch write lost");

  property p_dir_write;
    @(posedge clk) disable iff (!nrst)
    (wr && sel_dir) |=> 8'(port_direction) == $past(wdata);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("Direction write lost");

  property p_pull_write;
    @(posedge clk) disable iff (!nrst)
    (wr && sel_pull) |=> 8'(port_pullup_enable) == $past(wdata);
  endproperty
  a_pull_write: assert property (p_pull_write)
    else $error("Pull-up enable write lost");

  property p_func_write;
    @(posedge clk) disable iff (!nrst)
    (wr && sel_func) |=> 8'(port_function_select) == $past(wdata);
  endproperty
  a_func_write: assert property (p_func_write)
    else $error("Function select write lost");
endmodule

/* File: port5_pkg.sv */
// Package for the eight-pin port with wake-up and segment functions.
// Assumes byte-wide register port addressed by the printed 16-bit offsets.
package port5_pkg;
  localparam int          PORT_WIDTH      = 8;
  localparam int          ADDR_WIDTH      = 16;
  localparam int          SEG_SEL_WIDTH   = 4;
  // Register offsets
  localparam logic [15:0] ADDR_FUNC_SEL   = 16'hFFCC;
  localparam logic [15:0] ADDR_DATA_LATCH = 16'hFFD8;
  localparam logic [15:0] ADDR_PULLUP_EN  = 16'hFFE2;
  localparam logic [15:0] ADDR_DIRECTION  = 16'hFFE8;
  // Reset and read-back values
  localparam logic [7:0]  RESET_VALUE     = 8'h00;
  localparam logic [7:0]  DIR_READ_VALUE  = 8'hFF;
  localparam logic [7:0]  UNMAPPED_VALUE  = 8'h00;
  // Segment-select field positions
  localparam int          SEG_SEL_MSB     = 3;
  localparam int          SEG_SEL_LSB     = 0;
  // Operating modes of the chip
  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_SUBACTIVE,
    MODE_SLEEP,
    MODE_SUBSLEEP,
    MODE_WATCH,
    MODE_STANDBY
  } op_mode_e;
endpackage

/* File: port5_pin_cell.sv */
// Per-pin function decode for the port.
// Assumes register bits and segment select arrive as synchronous levels.
`timescale 1ns/1ps
module port5_pin_cell #(
  parameter bit UPPER_HALF = 1'b0
) (
  input  wire logic       direction,
  input  wire logic       latch,
  input  wire logic       wakeup_select_bit,
  input  wire logic       pullup_en,
  input  wire logic       seg_level,
  input  wire logic [3:0] segment_select_field,
  output logic            seg_use,
  output logic            drive_oe,
  output logic            drive_out,
  output logic            pullup_on,
  output logic            wake_use
);
  // Segment selection differs between upper and lower nibble
  wire logic seg_upper;
  wire logic seg_lower;
  wire logic gpio_use;
  assign seg_upper = segment_select_field[port5_pkg::SEG_SEL_MSB];
  assign seg_lower = segment_select_field[port5_pkg::SEG_SEL_MSB]
                   & segment_select_field[port5_pkg::SEG_SEL_LSB];
  assign seg_use   = UPPER_HALF ? seg_upper : seg_lower;
  assign wake_use  = ~seg_use & wakeup_select_bit;
  assign gpio_use  = ~seg_use & ~wakeup_select_bit;
  assign drive_oe  = seg_use | (gpio_use & direction);
  assign drive_out = seg_use ? seg_level : latch;
  assign pullup_on = pullup_en & ~direction & ~seg_use;
endmodule

/* File: port5_board_model.sv */
// Board side of the eight port pins: resolves each wire level.
// Assumes outputs from the port are registered on the same clock.
`timescale 1ns/1ps
module port5_board_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_on,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_in
);
  logic [7:0] last;
  // Floating wire flips each cycle so a stale level never reads as valid
  always_ff @(posedge clk)
  begin
    last <= pin_in;
  end
  // Port drive wins, then the board, then the pull-up
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                  pullup_on[i] ? 1'b1 : ~last[i];
  end
endmodule

/* File: tb_top.sv */
// Self-checking bench for the eight-pin port with board model.
// Assumes one-cycle strobes and read data in the cycle after rd.
`timescale 1ns/1ps
module tb_top;
  logic        clk = 0, nrst = 0, wr = 0, rd = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, rdata, lcd = 8'h96, ext_val = 8'h00;
  logic [7:0]  ext_en = 8'hFF, pin_in, pin_out, pin_oe, pullup_on;
  logic [7:0]  wakeup_in, seg_active;
  logic [3:0]  field = 4'h0;
  logic [2:0]  op_mode = 3'h0;
  int          failures = 0, checks_done = 0;
  // Free-running clock, 40 ns period
  always #20 clk = ~clk;
  port5_gpio port5_gpio_i (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .segment_select_field(field), .lcd_segment_output(lcd),
    .op_mode(op_mode), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_on(pullup_on), .wakeup_in(wakeup_in),
    .seg_active(seg_active));
  port5_board_model port5_board_model_i (.clk(clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_on(pullup_on), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(pin_in));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read strobe, then data sampled in the single cycle that holds it
  task rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Register write plus output register: two edges, one spare
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task t_reset;
    chk(pin_oe, 8'h00);
    @(posedge clk);
    nrst <= 1'b1;
    // Unmapped write must not reach any register
    wr_reg(16'hFFD0, 8'hFF);
    rd_chk(port5_pkg::ADDR_FUNC_SEL, 8'h00);
    rd_chk(port5_pkg::ADDR_DATA_LATCH, 8'h00);
    rd_chk(port5_pkg::ADDR_PULLUP_EN, 8'h00);
    rd_chk(port5_pkg::ADDR_DIRECTION, 8'hFF);
    rd_chk(16'hFFD0, 8'h00);
    settle;
    chk(pullup_on, 8'h00);
    $display("test reset done");
  endtask
  task t_dir_data;
    @(posedge clk);
    ext_val <= 8'h3C;
    wr_reg(port5_pkg::ADDR_DATA_LATCH, 8'hA5);
    wr_reg(port5_pkg::ADDR_DIRECTION, 8'h0F);
    rd_chk(port5_pkg::ADDR_DIRECTION, 8'hFF);
    settle;
    chk(pin_oe, 8'h0F);
    chk(pin_out & 8'h0F, 8'h05);
    rd_chk(port5_pkg::ADDR_DATA_LATCH, 8'h35);
    $display("test direction and data done");
  endtask
  task t_pullup;
    wr_reg(port5_pkg::ADDR_PULLUP_EN, 8'hFF);
    rd_chk(port5_pkg::ADDR_PULLUP_EN, 8'hFF);
    settle;
    chk(pullup_on, 8'hF0);
    $display("test pull-up done");
  endtask
  task t_wake;
    wr_reg(port5_pkg::ADDR_DIRECTION, 8'hFF);
    wr_reg(port5_pkg::ADDR_FUNC_SEL, 8'hF0);
    settle;
    chk(pin_oe, 8'h0F);
    chk(wakeup_in, 8'h30);
    wr_reg(port5_pkg::ADDR_FUNC_SEL, 8'h00);
    wr_reg(port5_pkg::ADDR_DIRECTION, 8'h00);
    $display("test wake-up done");
  endtask
  // Every field value, both pin halves
  task t_seg;
    logic [7:0] e;
    for (int f = 0; f < 16; f++)
    begin
      @(posedge clk);
      field <= f[3:0];
      settle;
      e = {{4{f[3]}}, {4{f[3] & f[0]}}};
      chk(seg_active, e);
      chk(pin_oe, e);
      chk(pin_out & e, lcd & e);
    end
    // Segment use overrides a direction and latch set for output
    @(posedge clk);
    field <= 4'h9;
    wr_reg(port5_pkg::ADDR_DIRECTION, 8'hFF);
    settle;
    chk(seg_active, 8'hFF);
    chk(pin_out, lcd);
    @(posedge clk);
    field <= 4'h0;
    $display("test segment select done");
  endtask
  // Sleep-type modes hold old outputs while direction changes
  task t_hold(input logic [2:0] m);
    wr_reg(port5_pkg::ADDR_DIRECTION, 8'h0F);
    settle;
    @(posedge clk);
    op_mode <= m;
    wr_reg(port5_pkg::ADDR_DIRECTION, 8'hF0);
    settle;
    chk(pin_oe, 8'h0F);
    @(posedge clk);
    op_mode <= port5_pkg::MODE_ACTIVE;
    settle;
    chk(pin_oe, 8'hF0);
  endtask
  // Standby floats all but pulled-up pins; subactive works normally
  task t_modes;
    t_hold(port5_pkg::MODE_SLEEP);
    t_hold(port5_pkg::MODE_SUBSLEEP);
    t_hold(port5_pkg::MODE_WATCH);
    @(posedge clk);
    op_mode <= port5_pkg::MODE_STANDBY;
    ext_en <= 8'h00;
    settle;
    chk(pin_oe, 8'h00);
    chk(pullup_on, 8'h0F);
    chk(pin_in & 8'h0F, 8'h0F);
    @(posedge clk);
    op_mode <= port5_pkg::MODE_SUBACTIVE;
    ext_en <= 8'hFF;
    settle;
    chk(pin_oe, 8'hF0);
    wr_reg(port5_pkg::ADDR_DIRECTION, 8'h0F);
    settle;
    chk(pin_oe, 8'h0F);
    @(posedge clk);
    op_mode <= port5_pkg::MODE_ACTIVE;
    $display("test operating modes done");
  endtask
  // Reset in mid-run clears registers and floats pins at once
  task t_rereset;
    @(posedge clk);
    nrst <= 1'b0;
    #1;
    chk(pin_oe, 8'h00);
    chk(pullup_on, 8'h00);
    @(posedge clk);
    nrst <= 1'b1;
    rd_chk(port5_pkg::ADDR_PULLUP_EN, 8'h00);
    rd_chk(port5_pkg::ADDR_FUNC_SEL, 8'h00);
    wr_reg(port5_pkg::ADDR_DIRECTION, 8'hFF);
    rd_chk(port5_pkg::ADDR_DATA_LATCH, 8'h00);
    settle;
    chk(pin_oe, 8'hFF);
    chk(pin_out, 8'h00);
    $display("test mid-run reset done");
  endtask
  task stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence after ten reset cycles
  initial
  begin
    repeat (10) @(posedge clk);
    t_reset;
    t_dir_data;
    t_pullup;
    t_wake;
    t_seg;
    t_modes;
    t_rereset;
    stop_test;
  end
  // Whole run needs well under 1000 cycles
  initial
  begin
    #200000;
    failures++;
    stop_test;
  end
endmodule
